/* File: pkg/isct_pkg.sv */
// Package for the serial clock timing and frame monitor block.
// Holds register offsets, field positions and reset values. It assumes a 32-bit
// classic Wishbone bus with byte addresses.
package isct_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] ISCT_OFS_CLOCK_CONFIG = 8'h1c;
   localparam logic [7:0] ISCT_OFS_RISE_LIMIT   = 8'h20;
   localparam logic [7:0] ISCT_OFS_FRAME_MON    = 8'h80;
   localparam logic [7:0] ISCT_OFS_PLUS_SPEED   = 8'h90;
   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [31:0] ISCT_RST_CLOCK_CONFIG = 32'h0000_0000;
   localparam logic [31:0] ISCT_RST_RISE_LIMIT   = 32'h0000_0002;
   localparam logic [31:0] ISCT_RST_FRAME_MON    = 32'h0000_0000;
   localparam logic [31:0] ISCT_RST_PLUS_SPEED   = 32'h0000_0000;
   ////////////////////////////////////////////////////////////////////////////
   // Clock configuration, rise limit and plus speed fields
   localparam int ISCT_FAST_BIT  = 15;
   localparam int ISCT_DUTY_BIT  = 14;
   localparam int ISCT_DIV_MSB   = 11;
   localparam int ISCT_DIV_W     = 12;
   localparam int ISCT_RISE_MSB  = 5;
   localparam int ISCT_RISE_W    = 6;
   localparam int ISCT_PLUS_BIT  = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Frame monitor fields
   localparam int ISCT_FLAG_LSB  = 12;
   localparam int ISCT_FLAG_MSB  = 15;
   localparam int ISCT_RXLVL_BIT = 9;
   localparam int ISCT_TXLVL_BIT = 8;
   localparam int ISCT_IEN_LSB   = 4;
   localparam int ISCT_IEN_MSB   = 7;
   localparam int ISCT_TOEN_BIT  = 1;
   localparam int ISCT_SIDE_EN_BIT = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Phase multipliers of the divider value and the phase counter width
   localparam logic [4:0] ISCT_MUL_ONE     = 5'h01;
   localparam logic [4:0] ISCT_MUL_TWO     = 5'h02;
   localparam logic [4:0] ISCT_MUL_NINE    = 5'h09;
   localparam logic [4:0] ISCT_MUL_SIXTEEN = 5'h10;
   localparam int         ISCT_CNT_W       = 17;
endpackage : isct_pkg

/* File: logic/isct_edge_sync.sv */
// Two-stage synchroniser with edge detection for one asynchronous input.
// Assumes the input is a pin outside the clk_sys domain.
`timescale 1ns/1ps
module isct_edge_sync #(
   parameter int STAGES = 2
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   // Asynchronous input
   input  wire logic async_in,
   // Synchronised outputs
   output logic      level,
   output logic      rise,
   output logic      fall
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [STAGES-1:0] chain;
      logic              last;
      logic              rise;
      logic              fall;
   } isct_sync_t;

   isct_sync_t s_q;
   isct_sync_t s_d;

   if (STAGES < 2) begin : g_bad
      $error("isct_edge_sync needs at least two stages");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Only the last stage feeds the edge logic; the first is never looked at
   always_comb begin
      s_d       = s_q;
      s_d.chain = {s_q.chain[STAGES-2:0], async_in};
      s_d.last  = s_q.chain[STAGES-1];
      s_d.rise  = s_q.chain[STAGES-1] & ~s_q.last;
      s_d.fall  = ~s_q.chain[STAGES-1] & s_q.last;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level = s_q.last;
   assign rise  = s_q.rise;
   assign fall  = s_q.fall;
endmodule : isct_edge_sync

/* File: logic/isct_top.sv */
// Serial clock timing configuration, clock generator and frame monitor.
// Assumes a classic Wishbone master on clk_sys and frame/clock pins that are
// asynchronous to clk_sys; the protocol core drives scl_run on clk_sys.
`timescale 1ns/1ps
module isct_top (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Interrupt
   output logic             irq,
   // Protocol core request for clock generation
   input  wire logic        scl_run,
   // Serial clock pin, open drain
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   // Side interface frame pins
   input  wire logic        rx_frame,
   input  wire logic        tx_frame,
   // Side interface controls for the core
   output logic             side_interface_en,
   output logic             side_timeout_en,
   output logic             plus_speed_en,
   output logic [5:0]       max_rise_count
);
   import isct_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   // The phase counter must hold sixteen times the widest divider
   if (ISCT_CNT_W < ISCT_DIV_W + 4) begin : g_bad_cnt
      $error("isct_top phase counter too narrow for the divider");
   end
   if (ISCT_DIV_MSB != ISCT_DIV_W - 1 || ISCT_RISE_MSB != ISCT_RISE_W - 1) begin : g_bad_field
      $error("isct_top field limits disagree with field widths");
   end
   if (ISCT_RISE_W != $bits(max_rise_count)) begin : g_bad_rise
      $error("isct_top rise field does not fit its port");
   end

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [31:0]            dat;
      logic                   ack;
      logic                   irq;
      logic                   fast;
      logic                   duty;
      logic [ISCT_DIV_W-1:0]  div;
      logic [ISCT_RISE_W-1:0] rise;
      logic [3:0]             flags;
      logic [3:0]             ien;
      logic                   toen;
      logic                   side_en;
      logic                   plus;
      logic                   high;
      logic [ISCT_CNT_W-1:0]  cnt;
      logic                   scl_rel;
   } isct_state_t;

   isct_state_t st_q;
   isct_state_t st_d;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic rx_lvl;
   logic rx_rise;
   logic rx_fall;
   logic tx_lvl;
   logic tx_rise;
   logic tx_fall;
   logic scl_lvl;

   isct_edge_sync #(.STAGES(2)) u_rx_sync (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in (rx_frame),
      .level    (rx_lvl),
      .rise     (rx_rise),
      .fall     (rx_fall)
   );

   isct_edge_sync #(.STAGES(2)) u_tx_sync (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in (tx_frame),
      .level    (tx_lvl),
      .rise     (tx_rise),
      .fall     (tx_fall)
   );

   isct_edge_sync #(.STAGES(2)) u_scl_sync (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in (scl_i),
      .level    (scl_lvl),
      .rise     (),
      .fall     ()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Byte lane merge, so half-word and word writes both land
   function automatic logic [31:0] isct_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  sel
   );
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : isct_merge

   ////////////////////////////////////////////////////////////////////////////
   // Register images
   logic [31:0] clk_img;
   logic [31:0] rise_img;
   logic [31:0] mon_img;
   logic [31:0] plus_img;

   always_comb begin
      clk_img = '0;
      clk_img[ISCT_FAST_BIT]     = st_q.fast;
      clk_img[ISCT_DUTY_BIT]     = st_q.duty;
      clk_img[ISCT_DIV_MSB:0]    = st_q.div;
      rise_img = '0;
      rise_img[ISCT_RISE_MSB:0]  = st_q.rise;
      mon_img = '0;
      mon_img[ISCT_FLAG_MSB:ISCT_FLAG_LSB] = st_q.flags;
      mon_img[ISCT_RXLVL_BIT]    = rx_lvl;
      mon_img[ISCT_TXLVL_BIT]    = tx_lvl;
      mon_img[ISCT_IEN_MSB:ISCT_IEN_LSB] = st_q.ien;
      mon_img[ISCT_TOEN_BIT]     = st_q.toen;
      mon_img[ISCT_SIDE_EN_BIT]  = st_q.side_en;
      plus_img = '0;
      plus_img[ISCT_PLUS_BIT]    = st_q.plus;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write images: clock, rise and plus speed registers after a byte lane merge of the bus data
   logic [31:0] clk_wimg;
   logic [31:0] rise_wimg;
   logic [31:0] plus_wimg;

   always_comb begin
      clk_wimg  = isct_merge(clk_img, wb_dat_i, wb_sel_i);
      rise_wimg = isct_merge(rise_img, wb_dat_i, wb_sel_i);
      plus_wimg = isct_merge(plus_img, wb_dat_i, wb_sel_i);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phase lengths in clk_sys periods
   logic                  fast_timing;
   logic [4:0]            mul_high;
   logic [4:0]            mul_low;
   logic [ISCT_CNT_W-1:0] len_high;
   logic [ISCT_CNT_W-1:0] len_low;

   always_comb begin
      // Plus speed uses the fast timing formulas too
      fast_timing = st_q.fast | st_q.plus;
      mul_high    = ISCT_MUL_ONE;
      mul_low     = ISCT_MUL_ONE;
      if (fast_timing && st_q.duty) begin
         mul_high = ISCT_MUL_NINE;
         mul_low  = ISCT_MUL_SIXTEEN;
      end else if (fast_timing) begin
         mul_low  = ISCT_MUL_TWO;
      end
      len_high = ISCT_CNT_W'(st_q.div) * ISCT_CNT_W'(mul_high);
      len_low  = ISCT_CNT_W'(st_q.div) * ISCT_CNT_W'(mul_low);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode and next state
   logic        req;
   logic        wr;
   logic [31:0] rdata;
   logic [3:0]  edges;
   logic [3:0]  keep;

   always_comb begin
      st_d  = st_q;
      req   = wb_cyc_i & wb_stb_i & ~st_q.ack;
      wr    = req & wb_we_i;
      rdata = '0;
      keep  = 4'hf;

      // Address decode; unmapped offsets read zero and ignore writes
      if (wb_adr_i == ISCT_OFS_CLOCK_CONFIG) begin
         rdata = clk_img;
      end else if (wb_adr_i == ISCT_OFS_RISE_LIMIT) begin
         rdata = rise_img;
      end else if (wb_adr_i == ISCT_OFS_FRAME_MON) begin
         rdata = mon_img;
      end else if (wb_adr_i == ISCT_OFS_PLUS_SPEED) begin
         rdata = plus_img;
      end

      // Answer one cycle after the request, then drop for one cycle
      st_d.ack = req;
      st_d.dat = req ? rdata : '0;

      if (wr && wb_adr_i == ISCT_OFS_CLOCK_CONFIG) begin
         st_d.fast  = clk_wimg[ISCT_FAST_BIT];
         st_d.duty  = clk_wimg[ISCT_DUTY_BIT];
         st_d.div   = clk_wimg[ISCT_DIV_MSB:0];
      end else if (wr && wb_adr_i == ISCT_OFS_RISE_LIMIT) begin
         st_d.rise  = rise_wimg[ISCT_RISE_MSB:0];
      end else if (wr && wb_adr_i == ISCT_OFS_FRAME_MON) begin
         if (wb_sel_i[1]) begin
            keep = wb_dat_i[ISCT_FLAG_MSB:ISCT_FLAG_LSB];
         end
         if (wb_sel_i[0]) begin
            st_d.ien     = wb_dat_i[ISCT_IEN_MSB:ISCT_IEN_LSB];
            st_d.toen    = wb_dat_i[ISCT_TOEN_BIT];
            st_d.side_en = wb_dat_i[ISCT_SIDE_EN_BIT];
         end
      end else if (wr && wb_adr_i == ISCT_OFS_PLUS_SPEED) begin
         st_d.plus  = plus_wimg[ISCT_PLUS_BIT];
      end

      // Edges count only while the side interface is on; a new edge beats a clear
      edges = {rx_rise, rx_fall, tx_rise, tx_fall} & {4{st_q.side_en}};
      st_d.flags = (st_q.flags & keep) | edges;

      // Level interrupt, registered in the same cycle as the flags
      st_d.irq = |(st_d.flags & st_d.ien);

      // Clock generator; a zero divider leaves SCL released
      if (!scl_run || st_q.div == '0) begin
         st_d.scl_rel = 1'b1;
         st_d.high    = 1'b1;
         st_d.cnt     = '0;
      end else if (st_q.high) begin
         // High time starts once the pin is really high, so stretching is honoured
         // Trade-off: the pin stays high three cycles beyond the count, the synchroniser lag
         if (scl_lvl) begin
            if (st_q.cnt >= len_high - 1'b1) begin
               st_d.high    = 1'b0;
               st_d.scl_rel = 1'b0;
               st_d.cnt     = '0;
            end else begin
               st_d.cnt = st_q.cnt + 1'b1;
            end
         end
      end else begin
         if (st_q.cnt >= len_low - 1'b1) begin
            st_d.high    = 1'b1;
            st_d.scl_rel = 1'b1;
            st_d.cnt     = '0;
         end else begin
            st_d.cnt = st_q.cnt + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st_q         <= '0;
         st_q.fast    <= ISCT_RST_CLOCK_CONFIG[ISCT_FAST_BIT];
         st_q.duty    <= ISCT_RST_CLOCK_CONFIG[ISCT_DUTY_BIT];
         st_q.div     <= ISCT_RST_CLOCK_CONFIG[ISCT_DIV_MSB:0];
         st_q.rise    <= ISCT_RST_RISE_LIMIT[ISCT_RISE_MSB:0];
         st_q.flags   <= ISCT_RST_FRAME_MON[ISCT_FLAG_MSB:ISCT_FLAG_LSB];
         st_q.ien     <= ISCT_RST_FRAME_MON[ISCT_IEN_MSB:ISCT_IEN_LSB];
         st_q.toen    <= ISCT_RST_FRAME_MON[ISCT_TOEN_BIT];
         st_q.side_en <= ISCT_RST_FRAME_MON[ISCT_SIDE_EN_BIT];
         st_q.plus    <= ISCT_RST_PLUS_SPEED[ISCT_PLUS_BIT];
         st_q.high    <= 1'b1;
         st_q.scl_rel <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all from the state register except scl_o, which is tied low
   assign wb_dat_o          = st_q.dat;
   assign wb_ack_o          = st_q.ack;
   assign irq               = st_q.irq;
   assign scl_o             = 1'b0;
   assign scl_oe            = ~st_q.scl_rel;
   assign side_interface_en = st_q.side_en;
   assign side_timeout_en   = st_q.toen;
   assign plus_speed_en     = st_q.plus;
   assign max_rise_count    = st_q.rise;
endmodule : isct_top

/* File: bench/isct_checker.sv */
// Port checker for the serial clock timing block.
// Assumes one clk_sys domain; bound to isct_top from the bench top.
`timescale 1ns/1ps
module isct_checker
   import isct_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // Bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Interrupt and clock pin
   input wire logic        irq,
   input wire logic        scl_run,
   input wire logic        scl_i,
   input wire logic        scl_o,
   input wire logic        scl_oe,
   // Frame pins and controls
   input wire logic        rx_frame,
   input wire logic        tx_frame,
   input wire logic        side_interface_en,
   input wire logic        side_timeout_en,
   input wire logic        plus_speed_en,
   input wire logic [5:0]  max_rise_count
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   logic wr_lo;
   assign wr_lo = wb_ack_o && wb_we_i && wb_sel_i[0];
   ////////////////////////////////////////////////////////////////////////////
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   irq_pair_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ISCT_OFS_FRAME_MON
      && (wb_dat_o[15:12] & wb_dat_o[7:4]) != 4'h0 |-> ##[0:1] irq) else $error("irq missing");
   side_en_a: assert property (wr_lo && wb_adr_i == ISCT_OFS_FRAME_MON
      |-> ##2 side_interface_en == $past(wb_dat_i[0], 2)) else $error("side enable wrong");
   tmo_en_a: assert property (wr_lo && wb_adr_i == ISCT_OFS_FRAME_MON
      |-> ##2 side_timeout_en == $past(wb_dat_i[1], 2)) else $error("timeout enable wrong");
   plus_en_a: assert property (wr_lo && wb_adr_i == ISCT_OFS_PLUS_SPEED
      |-> ##2 plus_speed_en == $past(wb_dat_i[0], 2)) else $error("plus speed enable wrong");
   rise_cnt_a: assert property (wr_lo && wb_adr_i == ISCT_OFS_RISE_LIMIT
      |-> ##2 max_rise_count == $past(wb_dat_i[5:0], 2)) else $error("rise field wrong");
   scl_idle_a: assert property (!scl_run [*2] |-> !scl_oe)
      else $error("clock pin pulled while stopped");
   scl_drain_a: assert property (scl_oe |-> !scl_o)
      else $error("clock pin driven high");
   cover property (wb_ack_o && wb_we_i);
   cover property ($rose(irq));
   cover property ($rose(scl_oe));
endmodule : isct_checker

/* File: bench/isct_scl_slave.sv */
// Far side of the clock wire: pull-up plus a slave that may stretch low.
// Assumes the bench sets the stretch length between runs.
`timescale 1ns/1ps
module isct_scl_slave (
   // Clock
   input wire logic       clk_sys,
   // Clock wire
   input wire logic       scl_o,
   input wire logic       scl_oe,
   input wire logic [3:0] stretch,
   output logic           scl_line
);
   logic [3:0] hold_q = 4'h0;
   // Stretch starts as the master lets go, so the wire never glitches high
   always_ff @(posedge clk_sys) begin
      if (scl_oe) begin
         hold_q <= stretch;
      end else if (hold_q != 4'h0) begin
         hold_q <= hold_q - 4'h1;
      end
   end
   assign scl_line = (scl_oe ? scl_o : 1'b1) && hold_q == 4'h0;
endmodule : isct_scl_slave

/* File: bench/tb_isct_top.sv */
// Self-checking bench for the serial clock timing block.
// Assumes the design, its package, the checker and the clock partner.
`timescale 1ns/1ps
module tb_isct_top;
   import isct_pkg::*;
   localparam int DIV = 3;
   localparam logic [7:0] OFS [4] = '{ISCT_OFS_CLOCK_CONFIG, ISCT_OFS_RISE_LIMIT, ISCT_OFS_FRAME_MON,
                                      ISCT_OFS_PLUS_SPEED};
   localparam logic [31:0] MSK [4] = '{32'h0000_cfff, 32'h0000_003f, 32'h0000_00f3, 32'h0000_0001};
   // Mode table: fast, duty, plus, stretch
   localparam logic [6:0] MODES [5] = '{7'h00, 7'h40, 7'h62, 7'h30, 7'h20};
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        wb_ack_o, irq, scl_i, scl_o, scl_oe;
   logic        scl_run = 1'b0, rx_frame = 1'b0, tx_frame = 1'b0;
   logic        side_interface_en, side_timeout_en, plus_speed_en;
   logic [5:0]  max_rise_count;
   logic [3:0]  stretch = 4'h0;
   logic [31:0] seed = 32'hb24f9201;
   logic [31:0] exp_q [$];
   int          n_errors = 0, samples_checked = 0;
   int          exp_l, exp_h, lcnt = 0, hcnt = 0, nlow = 0;
   bit          armed = 0, seen = 0;
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      // 125 MHz is a multiple of 25 but not of 3, so duty 1 divides evenly
      forever #4 clk_sys = ~clk_sys;
   end
   isct_top dut_u (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .irq(irq), .scl_run(scl_run), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .rx_frame(rx_frame),
      .tx_frame(tx_frame), .side_interface_en(side_interface_en), .side_timeout_en(side_timeout_en),
      .plus_speed_en(plus_speed_en), .max_rise_count(max_rise_count));
   isct_scl_slave far_u (.clk_sys(clk_sys), .scl_o(scl_o), .scl_oe(scl_oe), .stretch(stretch), .scl_line(scl_i));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic stop_test();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Reads note their expected data; the monitor compares it at ack
   task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
      int n;
      if (!we) exp_q.push_back(dat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         stop_test();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
   endtask : bus
   always @(posedge clk_sys) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         chk("read data", exp_q.pop_front(), wb_dat_o);
      end
   end
   // Phase lengths of the clock pin; the high phase allows for sync lag
   always @(posedge clk_sys) begin
      if (scl_oe === 1'b1) begin
         if (hcnt > 0 && armed && seen) begin
            samples_checked++;
            if (hcnt < exp_h || hcnt > exp_h + 4) begin
               n_errors++;
               $display("unexpected high phase expected %0d seen %0d", exp_h, hcnt);
            end
         end
         hcnt = 0;
         lcnt++;
      end else begin
         if (lcnt > 0 && armed) chk("low phase", exp_l, lcnt);
         if (lcnt > 0) nlow++;
         // The first high phase of a run follows no low phase and is not timed
         seen = armed && (seen || lcnt > 0);
         lcnt = 0;
         if (scl_run) hcnt++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d, e;
      logic [6:0]  md;
      logic [3:0]  fl;
      int          n;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      bus(0, OFS[0], 4'hf, ISCT_RST_CLOCK_CONFIG);
      bus(0, OFS[1], 4'hf, ISCT_RST_RISE_LIMIT);
      bus(0, OFS[2], 4'hf, ISCT_RST_FRAME_MON);
      bus(0, OFS[3], 4'hf, ISCT_RST_PLUS_SPEED);
      bus(1, 8'h24, 4'hf, 32'h0000_ffff);
      bus(0, 8'h24, 4'hf, 32'h0);
      // Writable bits only, so reserved bits keep their reset value
      for (int i = 0; i < 4; i++) begin
         d = xs() & MSK[i];
         e = xs() & MSK[i];
         bus(1, OFS[i], 4'hf, d);
         bus(0, OFS[i], 4'hf, d);
         bus(1, OFS[i], 4'h3, e);
         bus(1, OFS[i], 4'hc, {16'h0, ~e[15:0]});
         bus(0, OFS[i], 4'hf, e);
      end
      bus(1, OFS[2], 4'hf, 32'h0);
      rx_frame <= 1'b1;
      repeat (6) @(posedge clk_sys);
      bus(0, OFS[2], 4'hf, 32'h0000_0200);
      bus(1, OFS[2], 4'hf, 32'h0000_00f1);
      fl = 4'h0;
      for (int i = 0; i < 8; i++) begin
         d = xs();
         if (d[0] != rx_frame) fl |= d[0] ? 4'h8 : 4'h4;
         if (d[1] != tx_frame) fl |= d[1] ? 4'h2 : 4'h1;
         rx_frame <= d[0];
         tx_frame <= d[1];
         repeat (6) @(posedge clk_sys);
         bus(0, OFS[2], 4'hf, {16'h0, fl, 2'b0, d[0], d[1], 8'hf1});
         chk("irq", {31'h0, fl != 4'h0}, {31'h0, irq});
      end
      bus(1, OFS[2], 4'h1, 32'h0000_0001);
      repeat (2) @(posedge clk_sys);
      chk("irq", 32'h0, {31'h0, irq});
      bus(1, OFS[2], 4'h1, 32'h0000_00f1);
      repeat (2) @(posedge clk_sys);
      chk("irq", {31'h0, fl != 4'h0}, {31'h0, irq});
      fl &= 4'h7;
      bus(1, OFS[2], 4'h2, 32'h0000_7000);
      bus(0, OFS[2], 4'hf, {16'h0, fl, 2'b0, rx_frame, tx_frame, 8'hf1});
      bus(1, OFS[2], 4'h2, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk("irq", 32'h0, {31'h0, irq});
      for (int m = 0; m < 5; m++) begin
         md = MODES[m];
         exp_h = DIV;
         exp_l = DIV;
         if (md[6] || md[4]) begin
            exp_h = md[5] ? 9 * DIV : DIV;
            exp_l = md[5] ? 16 * DIV : 2 * DIV;
         end
         exp_h += md[3:0];
         bus(1, OFS[0], 4'h3, {16'h0, md[6:5], 2'b0, 12'(DIV)});
         bus(1, OFS[3], 4'hf, {31'h0, md[4]});
         stretch <= md[3:0];
         nlow = 0;
         armed = 1;
         scl_run <= 1'b1;
         n = 0;
         while (nlow < 3 && n < 3000) begin
            @(posedge clk_sys);
            n++;
         end
         if (n >= 3000) begin
            n_errors++;
            stop_test();
         end
         armed = 0;
         scl_run <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      stop_test();
   end
endmodule : tb_isct_top
bind isct_top isct_checker chk_u (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .irq(irq), .scl_run(scl_run), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .rx_frame(rx_frame),
   .tx_frame(tx_frame), .side_interface_en(side_interface_en), .side_timeout_en(side_timeout_en),
   .plus_speed_en(plus_speed_en), .max_rise_count(max_rise_count));
